// [logic/gtm_map.svh]
// Register offsets, field positions, reset values and timing figures of the gated timer
`ifndef GTM_MAP_SVH
`define GTM_MAP_SVH

// Byte offsets on the AHB-Lite register window
`define GTM_OFF_TIMER_CONTROL  8'h00
`define GTM_OFF_GATE_CONTROL   8'h04
`define GTM_OFF_COUNT          8'h08
`define GTM_OFF_FLAGS          8'h0c
`define GTM_ADDR_W             8

// timer_control fields
`define GTM_TC_CS_HI           7
`define GTM_TC_CS_LO           6
`define GTM_TC_PS_HI           5
`define GTM_TC_PS_LO           4
`define GTM_TC_SOSC_EN         3
`define GTM_TC_SYNC_DIS        2
`define GTM_TC_ON              0
`define GTM_TC_WMASK           8'hfd
`define GTM_TC_RESET           8'h00

// gate_control fields
`define GTM_GC_ENABLE          7
`define GTM_GC_POL             6
`define GTM_GC_TOGGLE          5
`define GTM_GC_SPM             4
`define GTM_GC_GO              3
`define GTM_GC_LEVEL           2
`define GTM_GC_SS_HI           1
`define GTM_GC_SS_LO           0
`define GTM_GC_RESET           8'h00

// Flags register fields, write one to clear
`define GTM_FL_ROLLOVER        0
`define GTM_FL_GATE_EVENT      1

// Instruction clock is one quarter of the system clock
`define GTM_INSTR_DIV          4
`define GTM_COUNT_RESET        16'h0000
`define GTM_HTRANS_NONSEQ      2'h2

`endif

// [logic/gtm_pkg.sv]
// Types shared by the gated timer design
package gtm_pkg;

  typedef enum logic [1:0] {
    GTM_CS_INSTR  = 2'h0,
    GTM_CS_SYSTEM = 2'h1,
    GTM_CS_EXTERN = 2'h2,
    GTM_CS_LFOSC  = 2'h3
  } gtm_clk_src_t;

  typedef enum logic [1:0] {
    GTM_GS_PIN    = 2'h0,
    GTM_GS_T0OVF  = 2'h1,
    GTM_GS_PAIRED = 2'h2,
    GTM_GS_TENTH  = 2'h3
  } gtm_gate_src_t;

  typedef enum logic [1:0] {
    GTM_BUS_IDLE   = 2'b01,
    GTM_BUS_RDWAIT = 2'b10
  } gtm_bus_state_t;

endpackage

// [logic/gtm_prescaler.sv]
// Input clock prescaler, divides count ticks by 1, 2, 4 or 8
`timescale 1ns/10ps
`default_nettype none
module gtm_prescaler #(
  parameter int unsigned WIDTH = 3
) (
  input  wire logic       ref_clk, // System clock
  input  wire logic       rst,     // Async reset
  input  wire logic       clear,   // Hold the divider at zero
  input  wire logic       tick_in, // One-cycle input tick
  input  wire logic [1:0] sel,     // Division select
  output logic            tick_out // One-cycle divided tick
);
  logic [WIDTH-1:0] divCount;
  logic [WIDTH-1:0] mask;

  // Mask of low bits that must be all ones before a tick passes
  always_comb begin
    mask = WIDTH'((1 << sel) - 1);
  end

  assign tick_out = tick_in && ((divCount & mask) == mask);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      divCount <= '0;
    end else if (clear) begin
      divCount <= '0;
    end else if (tick_in) begin
      divCount <= divCount + WIDTH'(1);
    end
  end
endmodule // gtm_prescaler
`default_nettype wire

// [logic/gtm_sync2.sv]
// Two-stage synchroniser for one level
`timescale 1ns/10ps
`default_nettype none
module gtm_sync2 (
  input  wire logic ref_clk,  // System clock
  input  wire logic rst,      // Async reset
  input  wire logic async_in, // Level to bring in
  output logic      sync_out  // Synchronised level
);
  logic stage1;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage1   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // gtm_sync2
`default_nettype wire

// [logic/gtm_timer.sv]
// Gated 16-bit timer with clock select, prescaler, gate logic and AHB-Lite registers
// Operation
// - Select 11 LFOSC, 01 system, 00 instruction
// - Select 10 external pin or secondary oscillator
// - Prescale 11 /8, 10 /4, 01 /2, 00 /1
// - Oscillator enable bit powers secondary oscillator
// - Sync disable only matters for external source
// - Timer off stops counting, clears toggle flop
// - Gate enable ignored while timer off
// - Gate polarity picks active-high or active-low
// - Toggle mode routes gate through toggle flop
// - Single-pulse mode controls counter gate
// - Go bit set while armed, hardware clears
// - Gate level shows gate regardless of enable
// - Gate source: pin, overflow, paired, tenth
// - Control bits reset to zero
// - Counter rolls over, sets rollover flag
// - Single pulse counts from edge, ends trailing
// - Falling gate level sets gate event flag
`timescale 1ns/10ps
`default_nettype none
`include "gtm_map.svh"
module gtm_timer #(
  parameter int unsigned COUNT_W = 16
) (
  input  wire logic        ref_clk,            // 40 MHz system clock
  input  wire logic        rst,                // Async reset, active high
  input  wire logic        hsel,               // AHB slave select
  input  wire logic [31:0] haddr,              // AHB address
  input  wire logic [1:0]  htrans,             // AHB transfer type
  input  wire logic        hwrite,             // AHB write
  input  wire logic [2:0]  hsize,              // AHB size, word only
  input  wire logic [31:0] hwdata,             // AHB write data
  input  wire logic        hready,             // AHB bus ready
  output logic      [31:0] hrdata,             // AHB read data
  output logic             hreadyout,          // AHB slave ready
  output logic             hresp,              // AHB response, always OKAY
  input  wire logic        lowFreqInternalOsc, // Low-frequency oscillator level
  input  wire logic        externalClockPin,   // External clock pin level
  input  wire logic        secondaryOscIn,     // Secondary oscillator output level
  input  wire logic        gatePin,            // Gate pin level
  input  wire logic        timer0Overflow,     // Eight-bit timer overflow
  input  wire logic        pairedTimerMatch,   // Paired timer period match
  input  wire logic        tenthTimerMatch,    // Tenth timer period match
  output logic             secondaryOscEnable, // Secondary oscillator enable
  output logic             rolloverFlag,       // Sticky rollover flag
  output logic             gateEventFlag       // Sticky gate event flag
);
  import gtm_pkg::*;

  logic [7:0]               timerControl;
  logic [7:0]               gateControl;
  logic [COUNT_W-1:0]       countPair;
  gtm_bus_state_t           busState;
  logic                     dpWrite;
  logic                     dpRead;
  logic [`GTM_ADDR_W-1:0]   dpAddr;
  logic                     addrAccept;
  logic                     wrTimerControl;
  logic                     wrGateControl;
  logic                     wrCount;
  logic                     wrFlags;

  gtm_clk_src_t             clkSrc;
  logic [1:0]               prescaleSel;
  logic                     oscEnable;
  logic                     syncDisable;
  logic                     timerOn;
  logic                     gateEnable;
  logic                     gatePol;
  logic                     toggleMode;
  logic                     singlePulseMode;
  logic                     pulseGo;
  gtm_gate_src_t            gateSrc;

  logic [1:0]               instrDiv;
  logic                     instrTick;
  logic                     extRaw;
  logic                     extSynced;
  logic                     extLevel;
  logic                     extPrev;
  logic                     lfPrev;
  logic                     srcTick;
  logic                     countTick;

  logic                     gateRaw;
  logic                     gatePolarised;
  logic                     gatePolPrev;
  logic                     toggleFlop;
  logic                     gateShaped;
  logic                     gateShapedPrev;
  logic                     pulseWindow;
  logic                     gateLevel;
  logic                     gateLevelPrev;
  logic                     countEnable;
  logic                     rollover;

  // Address decode helper used for both read mux and write strobes
  function automatic logic hit(input logic [`GTM_ADDR_W-1:0] a, input logic [`GTM_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  function automatic logic rising(input logic now, input logic prev);
    rising = now && !prev;
  endfunction

  assign clkSrc          = gtm_clk_src_t'(timerControl[`GTM_TC_CS_HI:`GTM_TC_CS_LO]);
  assign prescaleSel     = timerControl[`GTM_TC_PS_HI:`GTM_TC_PS_LO];
  assign oscEnable       = timerControl[`GTM_TC_SOSC_EN];
  assign syncDisable     = timerControl[`GTM_TC_SYNC_DIS];
  assign timerOn         = timerControl[`GTM_TC_ON];
  assign gateEnable      = gateControl[`GTM_GC_ENABLE];
  assign gatePol         = gateControl[`GTM_GC_POL];
  assign toggleMode      = gateControl[`GTM_GC_TOGGLE];
  assign singlePulseMode = gateControl[`GTM_GC_SPM];
  assign pulseGo         = gateControl[`GTM_GC_GO];
  assign gateSrc         = gtm_gate_src_t'(gateControl[`GTM_GC_SS_HI:`GTM_GC_SS_LO]);

  // ---------------- AHB-Lite slave ----------------
  assign addrAccept     = hsel && hready && (htrans == `GTM_HTRANS_NONSEQ) && (busState == GTM_BUS_IDLE);
  assign wrTimerControl = dpWrite && hit(dpAddr, `GTM_OFF_TIMER_CONTROL);
  assign wrGateControl  = dpWrite && hit(dpAddr, `GTM_OFF_GATE_CONTROL);
  assign wrCount        = dpWrite && hit(dpAddr, `GTM_OFF_COUNT);
  assign wrFlags        = dpWrite && hit(dpAddr, `GTM_OFF_FLAGS);

  // Reads take one wait state so a write just before is always visible
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busState  <= GTM_BUS_IDLE;
      dpWrite   <= 1'b0;
      dpRead    <= 1'b0;
      dpAddr    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      dpWrite <= addrAccept && hwrite;
      dpRead  <= addrAccept && !hwrite;
      if (addrAccept) begin
        dpAddr <= haddr[`GTM_ADDR_W-1:0];
      end
      unique case (busState)
        GTM_BUS_IDLE: begin
          if (addrAccept && !hwrite) begin
            busState  <= GTM_BUS_RDWAIT;
            hreadyout <= 1'b0;
          end
        end
        GTM_BUS_RDWAIT: begin
          busState  <= GTM_BUS_IDLE;
          hreadyout <= 1'b1;
        end
        default: begin
          busState  <= GTM_BUS_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // Read data; unmapped addresses read zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hrdata <= '0;
    end else if (dpRead) begin
      hrdata <= '0;
      if (hit(dpAddr, `GTM_OFF_TIMER_CONTROL)) begin
        hrdata[7:0] <= timerControl;
      end else if (hit(dpAddr, `GTM_OFF_GATE_CONTROL)) begin
        hrdata[7:0] <= gateControl;
      end else if (hit(dpAddr, `GTM_OFF_COUNT)) begin
        hrdata[COUNT_W-1:0] <= countPair;
      end else if (hit(dpAddr, `GTM_OFF_FLAGS)) begin
        hrdata[`GTM_FL_ROLLOVER]   <= rolloverFlag;
        hrdata[`GTM_FL_GATE_EVENT] <= gateEventFlag;
      end
    end
  end

  // ---------------- Control registers ----------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      timerControl <= `GTM_TC_RESET;
    end else if (wrTimerControl) begin
      timerControl <= hwdata[7:0] & `GTM_TC_WMASK;
    end
  end

  // Go bit: software write wins over the hardware clear in the same cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gateControl <= `GTM_GC_RESET;
    end else begin
      if (wrGateControl) begin
        gateControl[`GTM_GC_ENABLE:`GTM_GC_SPM] <= hwdata[`GTM_GC_ENABLE:`GTM_GC_SPM];
        gateControl[`GTM_GC_SS_HI:`GTM_GC_SS_LO] <= hwdata[`GTM_GC_SS_HI:`GTM_GC_SS_LO];
      end
      if (wrGateControl && hwdata[`GTM_GC_GO]) begin
        gateControl[`GTM_GC_GO] <= 1'b1;
      end else if (wrGateControl && !hwdata[`GTM_GC_GO]) begin
        gateControl[`GTM_GC_GO] <= 1'b0;
      end else if (pulseWindow && !gateShaped) begin
        gateControl[`GTM_GC_GO] <= 1'b0;
      end
      gateControl[`GTM_GC_LEVEL] <= gateLevel;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      secondaryOscEnable <= 1'b0;
    end else begin
      secondaryOscEnable <= oscEnable;
    end
  end

  // ---------------- Clock source selection ----------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      instrDiv <= '0;
    end else begin
      instrDiv <= instrDiv + 2'h1;
    end
  end
  assign instrTick = (instrDiv == 2'(`GTM_INSTR_DIV - 1));

  assign extRaw = oscEnable ? secondaryOscIn : externalClockPin;

  gtm_sync2 u_ext_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (extRaw),
    .sync_out (extSynced)
  );

  // Unsynchronised path still passes one edge register; pins are taken as synchronous
  assign extLevel = syncDisable ? extRaw : extSynced;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      extPrev <= 1'b0;
      lfPrev  <= 1'b0;
    end else begin
      extPrev <= extLevel;
      lfPrev  <= lowFreqInternalOsc;
    end
  end

  always_comb begin
    unique case (clkSrc)
      GTM_CS_INSTR:  srcTick = instrTick;
      GTM_CS_SYSTEM: srcTick = 1'b1;
      GTM_CS_EXTERN: srcTick = rising(extLevel, extPrev);
      GTM_CS_LFOSC:  srcTick = rising(lowFreqInternalOsc, lfPrev);
    endcase
  end

  gtm_prescaler #(
    .WIDTH (3)
  ) u_prescaler (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .clear    (!timerOn),
    .tick_in  (srcTick),
    .sel      (prescaleSel),
    .tick_out (countTick)
  );

  // ---------------- Gate processing ----------------
  always_comb begin
    unique case (gateSrc)
      GTM_GS_PIN:    gateRaw = gatePin;
      GTM_GS_T0OVF:  gateRaw = timer0Overflow;
      GTM_GS_PAIRED: gateRaw = pairedTimerMatch;
      GTM_GS_TENTH:  gateRaw = tenthTimerMatch;
    endcase
  end

  assign gatePolarised = gatePol ? gateRaw : !gateRaw;

  // Cleared and held clear while off so software controls which edge is measured
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      toggleFlop  <= 1'b0;
      gatePolPrev <= 1'b0;
    end else begin
      gatePolPrev <= gatePolarised;
      if (!toggleMode || !timerOn) begin
        toggleFlop <= 1'b0;
      end else if (rising(gatePolarised, gatePolPrev)) begin
        toggleFlop <= !toggleFlop;
      end
    end
  end

  assign gateShaped = toggleMode ? toggleFlop : gatePolarised;

  // Single pulse: open at the next rising edge while armed, close at the trailing edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pulseWindow    <= 1'b0;
      gateShapedPrev <= 1'b0;
    end else begin
      gateShapedPrev <= gateShaped;
      if (!singlePulseMode || !gateShaped) begin
        pulseWindow <= 1'b0;
      end else if (pulseGo && rising(gateShaped, gateShapedPrev)) begin
        pulseWindow <= 1'b1;
      end
    end
  end

  assign gateLevel = singlePulseMode ? (pulseWindow && gateShaped) : gateShaped;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gateLevelPrev <= 1'b0;
    end else begin
      gateLevelPrev <= gateLevel;
    end
  end

  // ---------------- Counter ----------------
  assign countEnable = timerOn && (!gateEnable || gateLevel);
  assign rollover    = countTick && countEnable && (&countPair);

  // A software write to the count takes precedence over an increment
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      countPair <= `GTM_COUNT_RESET;
    end else if (wrCount) begin
      countPair <= hwdata[COUNT_W-1:0];
    end else if (countTick && countEnable) begin
      countPair <= countPair + COUNT_W'(1);
    end
  end

  // Sticky flags: a set in the same cycle as a clear wins
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rolloverFlag  <= 1'b0;
      gateEventFlag <= 1'b0;
    end else begin
      if (rollover) begin
        rolloverFlag <= 1'b1;
      end else if (wrFlags && hwdata[`GTM_FL_ROLLOVER]) begin
        rolloverFlag <= 1'b0;
      end
      if (gateLevelPrev && !gateLevel) begin
        gateEventFlag <= 1'b1;
      end else if (wrFlags && hwdata[`GTM_FL_GATE_EVENT]) begin
        gateEventFlag <= 1'b0;
      end
    end
  end

endmodule // gtm_timer
`default_nettype wire

// [verification/gtm_far_side.sv]
// Far-side sources of the gated timer: oscillators, clock pin and gate levels
`timescale 1ns/10ps
`default_nettype none
module gtm_far_side (
  input  wire logic       ref_clk,            // System clock
  input  wire logic       rst,                // Async reset
  input  wire logic       extRun,             // Clock pin runs only while set
  input  wire logic       secondaryOscEnable, // Oscillator power
  input  wire logic [3:0] gateLv,             // Four gate source levels
  output logic            lowFreqInternalOsc, // Period 8 cycles
  output logic            externalClockPin,   // Period 6 cycles
  output logic            secondaryOscIn,     // Period 10 cycles
  output logic            gatePin,            // Gate source 0
  output logic            timer0Overflow,     // Gate source 1
  output logic            pairedTimerMatch,   // Gate source 2
  output logic            tenthTimerMatch     // Gate source 3
);
  logic [7:0] cnt;
  // Common multiple of all periods keeps every wave seamless at wrap
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt <= 8'h00;
    end else begin
      cnt <= (cnt == 8'h77) ? 8'h00 : cnt + 8'h01;
    end
  end
  always_ff @(posedge ref_clk) begin
    lowFreqInternalOsc <= (cnt % 8'h08) < 8'h04;
    externalClockPin   <= extRun && (cnt % 8'h06) < 8'h03;
    secondaryOscIn     <= secondaryOscEnable && (cnt % 8'h0a) < 8'h05;
  end
  assign {tenthTimerMatch, pairedTimerMatch, timer0Overflow, gatePin} = gateLv;
endmodule // gtm_far_side
`default_nettype wire

// [verification/gtm_timer_assertions.sv]
// Port-level assertions for the gated timer
`timescale 1ns/10ps
`default_nettype none
`include "gtm_map.svh"
module gtm_timer_assertions (
  input wire logic        ref_clk,            // System clock
  input wire logic        rst,                // Async reset
  input wire logic        hsel,               // AHB select
  input wire logic [31:0] haddr,              // AHB address
  input wire logic [1:0]  htrans,             // AHB transfer type
  input wire logic        hwrite,             // AHB write
  input wire logic [31:0] hwdata,             // AHB write data
  input wire logic        hready,             // AHB bus ready
  input wire logic [31:0] hrdata,             // AHB read data
  input wire logic        hreadyout,          // AHB slave ready
  input wire logic        hresp,              // AHB response
  input wire logic        secondaryOscEnable, // Oscillator enable
  input wire logic        rolloverFlag,       // Rollover flag
  input wire logic        gateEventFlag       // Gate event flag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic tk;
  logic rdTk;
  logic flWr;
  logic tcWr;
  assign tk   = hsel && hready && htrans == `GTM_HTRANS_NONSEQ;
  assign rdTk = tk && !hwrite;
  assign flWr = tk && hwrite && haddr[7:0] == `GTM_OFF_FLAGS;
  assign tcWr = tk && hwrite && haddr[7:0] == `GTM_OFF_TIMER_CONTROL;
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("response not OKAY");
  property p_rd_wait; rdTk |=> !hreadyout ##1 hreadyout; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  property p_wr_nowait; tk && hwrite |=> hreadyout; endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  property p_one_wait; !hreadyout |=> hreadyout; endproperty
  a_one_wait: assert property (p_one_wait) else $error("more than one wait cycle");
  property p_rd_hold; !$stable(hrdata) |-> $past(rdTk, 2); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data changed without read");
  property p_osc_set; tcWr ##2 1'b1 |=> secondaryOscEnable == $past(hwdata[`GTM_TC_SOSC_EN], 2); endproperty
  a_osc_set: assert property (p_osc_set) else $error("oscillator enable not written");
  property p_osc_hold; !$stable(secondaryOscEnable) |-> $past(tcWr, 3); endproperty
  a_osc_hold: assert property (p_osc_hold) else $error("oscillator enable moved alone");
  property p_roll_clr; $fell(rolloverFlag) |-> $past(flWr, 2) && $past(hwdata[`GTM_FL_ROLLOVER]); endproperty
  a_roll_clr: assert property (p_roll_clr) else $error("rollover flag lost");
  property p_gev_clr; $fell(gateEventFlag) |-> $past(flWr, 2) && $past(hwdata[`GTM_FL_GATE_EVENT]); endproperty
  a_gev_clr: assert property (p_gev_clr) else $error("gate event flag lost");
endmodule // gtm_timer_assertions
bind gtm_timer gtm_timer_assertions u_chk (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hrdata, .hreadyout, .hresp, .secondaryOscEnable, .rolloverFlag, .gateEventFlag);
`default_nettype wire

// [verification/test_gtm_timer.sv]
// Self-checking bench for the gated timer
`timescale 1ns/10ps
`default_nettype none
`include "gtm_map.svh"
module test_gtm_timer;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, extRun = 1'b0;
  logic [3:0]  gateLv = 4'h0;
  logic [2:0]  flg;
  logic        lowFreqInternalOsc, externalClockPin, secondaryOscIn, gatePin;
  logic        timer0Overflow, pairedTimerMatch, tenthTimerMatch;
  logic        secondaryOscEnable, rolloverFlag, gateEventFlag;
  int          n_fail = 0;
  int          comparisons = 0;
  int          cyc = 0;
  assign hready = hreadyout;
  always #12.5 ref_clk = ~ref_clk;
  gtm_timer u_dut (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .lowFreqInternalOsc, .externalClockPin, .secondaryOscIn, .gatePin, .timer0Overflow,
    .pairedTimerMatch, .tenthTimerMatch, .secondaryOscEnable, .rolloverFlag, .gateEventFlag);
  gtm_far_side u_far (.ref_clk, .rst, .extRun, .secondaryOscEnable, .gateLv, .lowFreqInternalOsc,
    .externalClockPin, .secondaryOscIn, .gatePin, .timer0Overflow, .pairedTimerMatch, .tenthTimerMatch);
  // Flags copied at mid-cycle so checks never race the edge that sets them
  always @(negedge ref_clk) flg <= {gateEventFlag, rolloverFlag, secondaryOscEnable};
  task automatic results;
    if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  task automatic near(input string nm, input int e, input logic [31:0] g);
    logic ok;
    ok = (g + 32'd4 >= e) && (g <= e + 4);
    comparisons++;
    if (ok !== 1'b1) begin
      $display("[ERR] %s expected %0d seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    htrans <= `GTM_HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    // Values read at the edge are still those the slave saw there
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask
  task automatic run(input string nm, input logic [7:0] tc, input int e);
    logic [31:0] a, b;
    wr(`GTM_OFF_COUNT, 32'h0);
    wr(`GTM_OFF_TIMER_CONTROL, {24'h0, tc});
    repeat (240) @(posedge ref_clk);
    wr(`GTM_OFF_TIMER_CONTROL, {24'h0, tc & 8'hfe});
    rd(`GTM_OFF_COUNT, a);
    repeat (8) @(posedge ref_clk);
    rd(`GTM_OFF_COUNT, b);
    near(nm, e, a);
    chk("stopped", a, b);
  endtask
  task automatic pulse;
    gateLv <= 4'h1;
    repeat (3) @(posedge ref_clk);
    gateLv <= 4'h0;
    repeat (30) @(posedge ref_clk);
  endtask
  task automatic t_regs;
    logic [31:0] q;
    rd(`GTM_OFF_TIMER_CONTROL, q);
    chk("tc_rst", 32'h0, q);
    rd(`GTM_OFF_GATE_CONTROL, q);
    chk("gc_rst", 32'h0, q & 32'hfb);
    rd(`GTM_OFF_COUNT, q);
    chk("cnt_rst", 32'h0, q);
    wr(8'h10, 32'hffffffff);
    rd(8'h10, q);
    chk("unmapped", 32'h0, q);
    wr(`GTM_OFF_TIMER_CONTROL, 32'hff);
    rd(`GTM_OFF_TIMER_CONTROL, q);
    chk("tc_rw", 32'hfd, q);
    chk("osc_on", 32'h1, {31'h0, flg[0]});
    wr(`GTM_OFF_TIMER_CONTROL, 32'h0);
    rd(`GTM_OFF_TIMER_CONTROL, q);
    chk("osc_off", 32'h0, {31'h0, flg[0]});
    wr(`GTM_OFF_GATE_CONTROL, 32'hf3);
    rd(`GTM_OFF_GATE_CONTROL, q);
    chk("gc_rw", 32'hf3, q & 32'hfb);
    wr(`GTM_OFF_GATE_CONTROL, 32'h0);
  endtask
  task automatic t_src;
    logic [7:0] tc [9] = '{8'h41, 8'h51, 8'h61, 8'h71, 8'h01, 8'hc1, 8'h85, 8'h81, 8'h89};
    int e [9] = '{240, 120, 60, 30, 60, 30, 40, 40, 24};
    extRun <= 1'b1;
    foreach (tc[i]) run("src_count", tc[i], e[i]);
    extRun <= 1'b0;
  endtask
  task automatic t_gate;
    logic [31:0] q;
    logic [3:0] one;
    for (int s = 0; s < 4; s++)
      for (int p = 0; p < 2; p++)
        for (int l = 0; l < 2; l++) begin
          one = 4'h1 << s;
          gateLv <= l[0] ? one : ~one;
          wr(`GTM_OFF_GATE_CONTROL, 32'h80 | (p << 6) | s);
          rd(`GTM_OFF_GATE_CONTROL, q);
          chk("gate_lvl", {31'h0, l[0] == p[0]}, {31'h0, q[2]});
          run("gated", 8'h41, (l == p) ? 240 : 0);
        end
    gateLv <= 4'h0;
    wr(`GTM_OFF_GATE_CONTROL, 32'h40);
    run("ungated", 8'h41, 240);
  endtask
  task automatic t_gev;
    gateLv <= 4'h1;
    wr(`GTM_OFF_FLAGS, 32'h3);
    repeat (3) @(posedge ref_clk);
    chk("gev_clr", 32'h0, {31'h0, flg[2]});
    gateLv <= 4'h0;
    repeat (4) @(posedge ref_clk);
    chk("gev_set", 32'h1, {31'h0, flg[2]});
  endtask
  task automatic t_tog;
    logic [31:0] a, b;
    wr(`GTM_OFF_GATE_CONTROL, 32'he0);
    wr(`GTM_OFF_COUNT, 32'h0);
    wr(`GTM_OFF_TIMER_CONTROL, 32'h41);
    pulse();
    rd(`GTM_OFF_COUNT, a);
    chk("tog_on", 32'h1, {31'h0, a > 32'd20});
    pulse();
    rd(`GTM_OFF_COUNT, a);
    repeat (20) @(posedge ref_clk);
    rd(`GTM_OFF_COUNT, b);
    chk("tog_off", a, b);
    pulse();
    wr(`GTM_OFF_TIMER_CONTROL, 32'h0);
    wr(`GTM_OFF_TIMER_CONTROL, 32'h41);
    rd(`GTM_OFF_COUNT, a);
    repeat (20) @(posedge ref_clk);
    rd(`GTM_OFF_COUNT, b);
    chk("tog_clr", a, b);
  endtask
  task automatic t_spm;
    logic [31:0] q, a;
    wr(`GTM_OFF_TIMER_CONTROL, 32'h0);
    wr(`GTM_OFF_COUNT, 32'h0);
    wr(`GTM_OFF_GATE_CONTROL, 32'hd8);
    wr(`GTM_OFF_TIMER_CONTROL, 32'h41);
    rd(`GTM_OFF_GATE_CONTROL, q);
    chk("go_armed", 32'h1, {31'h0, q[3]});
    rd(`GTM_OFF_COUNT, q);
    chk("spm_wait", 32'h0, q);
    pulse();
    rd(`GTM_OFF_GATE_CONTROL, q);
    chk("go_done", 32'h0, {31'h0, q[3]});
    rd(`GTM_OFF_COUNT, a);
    chk("spm_cnt", 32'h1, {31'h0, a != 32'h0});
    pulse();
    rd(`GTM_OFF_COUNT, q);
    chk("spm_blk", a, q);
  endtask
  task automatic t_roll;
    logic [31:0] q;
    wr(`GTM_OFF_GATE_CONTROL, 32'h0);
    wr(`GTM_OFF_TIMER_CONTROL, 32'h0);
    wr(`GTM_OFF_FLAGS, 32'h1);
    wr(`GTM_OFF_COUNT, 32'hfffe);
    chk("roll_clr", 32'h0, {31'h0, flg[1]});
    wr(`GTM_OFF_TIMER_CONTROL, 32'h41);
    repeat (6) @(posedge ref_clk);
    wr(`GTM_OFF_TIMER_CONTROL, 32'h0);
    rd(`GTM_OFF_COUNT, q);
    near("roll_cnt", 7, q);
    chk("roll_set", 32'h1, {31'h0, flg[1]});
    wr(`GTM_OFF_FLAGS, 32'h1);
    wr(`GTM_OFF_COUNT, 32'h0);
    chk("roll_clr", 32'h0, {31'h0, flg[1]});
  endtask
  // Whole run needs about 7k cycles; the ceiling leaves ample margin
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      results();
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_regs();
    t_src();
    t_gate();
    t_gev();
    t_tog();
    t_spm();
    t_roll();
    results();
  end
endmodule // test_gtm_timer
`default_nettype wire
